// ==== shared/oppnl_pkg.sv ====
// package of constants and carriers for the operator panel register bank
package oppnl_pkg;
    localparam int OPPNL_NBTN = 4;
    localparam int OPPNL_NWORD = 7;
    // word indexes of the shared block; byte address is four times the index
    localparam logic [3:0] IDX_TOP_SEL = 4'h0;
    localparam logic [3:0] IDX_BOT_SEL = 4'h1;
    localparam logic [3:0] IDX_TOP_LO = 4'h2;
    localparam logic [3:0] IDX_TOP_HI = 4'h3;
    localparam logic [3:0] IDX_BOT_LO = 4'h4;
    localparam logic [3:0] IDX_BOT_HI = 4'h5;
    localparam logic [3:0] IDX_STATUS = 4'h6;
    // extra registers of this block
    localparam logic [3:0] IDX_BTN_MODE = 4'h8;
    localparam logic [3:0] IDX_BASE_WORD = 4'h9;
    localparam logic [3:0] IDX_IRQ_STAT = 4'ha;
    localparam logic [3:0] IDX_IRQ_MASK = 4'hb;
    localparam logic [3:0] IDX_RAW_BTN = 4'hc;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [15:0] SEL_RESET = 16'h0001;
    localparam logic [15:0] MSG_MIN = 16'h0001;
    localparam logic [15:0] MSG_MAX = 16'h00a0;
    localparam logic [15:0] BASE_RESET = 16'h0000;
    localparam logic [3:0] MODE_RESET = 4'h0;
    localparam int BTN_FIELD_LSB = 0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] HSIZE_WORD = 3'b010;
    // one line of the display: message and two data words
    typedef struct packed {
        logic [15:0] sel;
        logic [15:0] lo;
        logic [15:0] hi;
    } oppnl_line_t;
    // interrupt events: press and release per button
    typedef struct packed {
        logic [3:0] release_ev;
        logic [3:0] press_ev;
    } oppnl_irq_t;
endpackage

// ==== rtl/oppnl_regs.sv ====
// operator panel host register bank with pushbuttons behind an AHB-Lite slave
// Functional notes
// - buttons one to four in status bits 0..3
// - lamp shows each button's status condition
// - per-button alternate/momentary type held in config
// - alternate: toggle lamp and status each press
// - momentary: lamp on only while held
// - base word address kept in panel config
// - seven-word layout same for every host
// - message selects carry number 1 to 160
// - double BCD: low word first, high next
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
module oppnl_regs
    import oppnl_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [OPPNL_NBTN-1:0] button_pin,
    output logic [OPPNL_NBTN-1:0] lamp,
    output oppnl_line_t top_line,
    output oppnl_line_t bottom_line,
    output logic irq
);
    logic [OPPNL_NBTN-1:0] sync1_reg, sync2_reg, sync3_reg;
    logic [OPPNL_NBTN-1:0] held_reg;
    logic [OPPNL_NBTN-1:0] alt_reg;
    logic [OPPNL_NBTN-1:0] mode_reg;
    logic [OPPNL_NBTN-1:0] state_next;
    logic [15:0] base_reg;
    logic [7:0] irq_stat_reg, irq_mask_reg;
    logic wr_pend_reg;
    logic [3:0] wr_idx_reg;
    logic [31:0] rd_next;
    logic addr_ok;
    logic [3:0] a_idx;
    logic [OPPNL_NBTN-1:0] press_ev, release_ev;
    oppnl_irq_t ev;

    // three-stage synchroniser for the button pins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end
        else
        begin
            sync1_reg <= button_pin;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // debounced held level: changes once stages two and three agree
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            held_reg <= '0;
        else
            for (int i = 0; i < OPPNL_NBTN; i++)
                if (sync2_reg[i] == sync3_reg[i])
                    held_reg[i] <= sync3_reg[i];
    end

    // edges of the held level
    always_comb
    begin
        for (int i = 0; i < OPPNL_NBTN; i++)
        begin
            press_ev[i] = (sync2_reg[i] == sync3_reg[i]) && sync3_reg[i] && !held_reg[i];
            release_ev[i] = (sync2_reg[i] == sync3_reg[i]) && !sync3_reg[i] && held_reg[i];
        end
        ev.press_ev = press_ev;
        ev.release_ev = release_ev;
    end

    // alternate toggle state, one flip per new press
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            alt_reg <= '0;
        else
            alt_reg <= alt_reg ^ press_ev;
    end

    // lamp and status condition: per-button type selects the source
    always_comb
    begin
        for (int i = 0; i < OPPNL_NBTN; i++)
            state_next[i] = mode_reg[i] ? (alt_reg[i] ^ press_ev[i]) : held_reg[i];
    end

    // lamp drivers follow the status condition
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            lamp <= '0;
        else
            lamp <= state_next;
    end

    // AHB address phase decode
    assign a_idx = haddr[5:2];
    assign addr_ok = (a_idx <= IDX_STATUS) || (a_idx >= IDX_BTN_MODE && a_idx <= IDX_RAW_BTN);

    // capture write address phase; writes land in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 4'h0;
        end
        else if (hready)
        begin
            wr_pend_reg <= hsel && htrans[1] && hwrite && addr_ok;
            wr_idx_reg <= a_idx;
        end
    end

    // display line words; message selects outside the legal range are ignored and keep their old value
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            top_line <= '{sel: SEL_RESET, lo: WORD_RESET, hi: WORD_RESET};
            bottom_line <= '{sel: SEL_RESET, lo: WORD_RESET, hi: WORD_RESET};
        end
        else if (wr_pend_reg)
        begin
            case (wr_idx_reg)
                IDX_TOP_SEL:
                    if (hwdata[15:0] >= MSG_MIN && hwdata[15:0] <= MSG_MAX)
                        top_line.sel <= hwdata[15:0];
                IDX_BOT_SEL:
                    if (hwdata[15:0] >= MSG_MIN && hwdata[15:0] <= MSG_MAX)
                        bottom_line.sel <= hwdata[15:0];
                IDX_TOP_LO: top_line.lo <= hwdata[15:0];
                IDX_TOP_HI: top_line.hi <= hwdata[15:0];
                IDX_BOT_LO: bottom_line.lo <= hwdata[15:0];
                IDX_BOT_HI: bottom_line.hi <= hwdata[15:0];
                default: ;
            endcase
        end
    end

    // configuration: button types and stored base word
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode_reg <= MODE_RESET;
            base_reg <= BASE_RESET;
        end
        else if (wr_pend_reg)
        begin
            if (wr_idx_reg == IDX_BTN_MODE)
                mode_reg <= hwdata[OPPNL_NBTN-1:0];
            if (wr_idx_reg == IDX_BASE_WORD)
                base_reg <= hwdata[15:0];
        end
    end

    // sticky interrupt status, set wins over write-one-to-clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
        end
        else
        begin
            if (wr_pend_reg && wr_idx_reg == IDX_IRQ_STAT)
                irq_stat_reg <= (irq_stat_reg & ~hwdata[7:0]) | ev;
            else
                irq_stat_reg <= irq_stat_reg | ev;
            if (wr_pend_reg && wr_idx_reg == IDX_IRQ_MASK)
                irq_mask_reg <= hwdata[7:0];
        end
    end

    // level interrupt output
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq <= 1'b0;
        else
            irq <= |(irq_stat_reg & irq_mask_reg);
    end

    // read mux for the address phase
    always_comb
    begin
        rd_next = 32'h0000_0000;
        case (a_idx)
            IDX_TOP_SEL: rd_next[15:0] = top_line.sel;
            IDX_BOT_SEL: rd_next[15:0] = bottom_line.sel;
            IDX_TOP_LO: rd_next[15:0] = top_line.lo;
            IDX_TOP_HI: rd_next[15:0] = top_line.hi;
            IDX_BOT_LO: rd_next[15:0] = bottom_line.lo;
            IDX_BOT_HI: rd_next[15:0] = bottom_line.hi;
            IDX_STATUS: rd_next[BTN_FIELD_LSB +: OPPNL_NBTN] = lamp;
            IDX_BTN_MODE: rd_next[OPPNL_NBTN-1:0] = mode_reg;
            IDX_BASE_WORD: rd_next[15:0] = base_reg;
            IDX_IRQ_STAT: rd_next[7:0] = irq_stat_reg;
            IDX_IRQ_MASK: rd_next[7:0] = irq_mask_reg;
            IDX_RAW_BTN: rd_next[OPPNL_NBTN-1:0] = held_reg;
            default: rd_next = 32'h0000_0000;
        endcase
    end

    // registered read data; zero-wait slave, always OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready && hsel && htrans[1] && !hwrite)
                hrdata <= rd_next;
        end
    end

    // alternate lamp holds while no new press
    property p_alt_hold;
        @(posedge hclk) disable iff (!hresetn)
        (mode_reg[2] && $past(mode_reg[2]) && !press_ev[2]) |=> lamp[2] == $past(lamp[2]);
    endproperty
    a_alt_hold: assert property (p_alt_hold) else $error("alternate lamp moved unpressed");
    // alternate button toggles lamp on press
    property p_alt_toggle;
        @(posedge hclk) disable iff (!hresetn)
        (mode_reg[0] && $past(mode_reg[0]) && press_ev[0])
            |=> lamp[0] != $past(lamp[0]);
    endproperty
    a_alt_toggle: assert property (p_alt_toggle) else $error("alternate lamp did not toggle");
    // momentary button lamp follows held level
    property p_mom_follow;
        @(posedge hclk) disable iff (!hresetn)
        (!mode_reg[1] && !(wr_pend_reg && wr_idx_reg == IDX_BTN_MODE)) |=> lamp[1] == $past(held_reg[1]);
    endproperty
    a_mom_follow: assert property (p_mom_follow) else $error("momentary lamp not held");
    // held level follows pin after synchroniser
    sequence s_pin_stable;
        button_pin[2] ##1 button_pin[2] ##1 button_pin[2];
    endsequence
    property p_sync;
        @(posedge hclk) disable iff (!hresetn)
        s_pin_stable |-> ##2 held_reg[2];
    endproperty
    a_sync: assert property (p_sync) else $error("button level not caught");
    // message select never leaves 1..160
    property p_sel_range;
        @(posedge hclk) disable iff (!hresetn)
        top_line.sel >= MSG_MIN && top_line.sel <= MSG_MAX
            && bottom_line.sel >= MSG_MIN && bottom_line.sel <= MSG_MAX;
    endproperty
    a_sel_range: assert property (p_sel_range) else $error("message number out of range");
    // status read shows lamps in low bits, zero above
    property p_status_read;
        @(posedge hclk) disable iff (!hresetn)
        (hready && hsel && htrans[1] && !hwrite && a_idx == IDX_STATUS)
            |=> hrdata[31:4] == 28'h0 && hrdata[3:0] == $past(lamp);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");
    // stored base word reads back what was written
    property p_base_store;
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend_reg && wr_idx_reg == IDX_BASE_WORD) |=> base_reg == $past(hwdata[15:0]);
    endproperty
    a_base_store: assert property (p_base_store) else $error("base word not kept");
    // interrupt event not lost to a concurrent clear
    property p_irq_set_wins;
        @(posedge hclk) disable iff (!hresetn)
        ev[0] |=> irq_stat_reg[0];
    endproperty
    a_irq_set_wins: assert property (p_irq_set_wins) else $error("press event lost");
    // double data words stored by position
    property p_word_order;
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend_reg && wr_idx_reg == IDX_TOP_HI) |=> top_line.hi == $past(hwdata[15:0])
            && top_line.lo == $past(top_line.lo);
    endproperty
    a_word_order: assert property (p_word_order) else $error("data word order wrong");
    // slave always answers OKAY
    property p_okay;
        @(posedge hclk) disable iff (!hresetn)
        ##1 !hresp;
    endproperty
    a_okay: assert property (p_okay) else $error("non-OKAY response");
endmodule

// ==== test/oppnl_host.sv ====
// host-side bus master with per-scan copy of the panel status word
`timescale 1ns/1ps
module oppnl_host
    import oppnl_pkg::*;
(
    input wire logic hclk,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    logic [15:0] status_bits; // bit storage of the status word
    logic [7:0] status_lo, status_hi; // two byte locations of an 8-bit host
    // bus idle at time zero
    initial
    begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0000_0000;
        status_bits = 16'h0000;
    end
    // one single word transfer, held until hready is seen at each phase
    task automatic xfer(input logic wr, input logic [3:0] idx, input logic [15:0] d,
        output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {26'h0, idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {16'h0000, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // status word copied into bit storage once per scan
    task automatic scan(output logic [31:0] r);
        xfer(1'b0, IDX_STATUS, 16'h0000, r);
        status_lo = r[7:0];
        status_hi = r[15:8];
        status_bits = {status_hi, status_lo};
    endtask
endmodule

// ==== test/tb.sv ====
// self-checking bench for the operator panel register bank
`timescale 1ns/1ps
module tb
    import oppnl_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] button_pin = 4'h0;
    logic [3:0] lamp;
    oppnl_line_t top_line, bottom_line;
    int miscompares = 0;
    int tests_run = 0;
    int mdl_word [7];
    int mdl_lamp = 0;
    int mdl_alt = 0;
    int mdl_mode = 0;
    int prev_pin = 0;
    // 20 MHz clock
    always #25 hclk = ~hclk;
    oppnl_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .button_pin(button_pin), .lamp(lamp), .top_line(top_line),
        .bottom_line(bottom_line), .irq(irq));
    oppnl_host i_host (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    // compare and count
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] idx, input logic [15:0] d);
        i_host.xfer(1'b1, idx, d, rd);
    endtask
    task automatic rdc(input logic [3:0] idx, input logic [31:0] exp);
        i_host.xfer(1'b0, idx, 16'h0000, rd);
        chk(exp, rd);
    endtask
    // drive buttons, step the lamp model, check lamp, status and raw view
    task automatic press(input logic [3:0] v);
        button_pin <= v;
        repeat (8) @(posedge hclk);
        for (int i = 0; i < 4; i++)
        begin
            if (v[i] && !prev_pin[i])
                mdl_alt[i] = ~mdl_alt[i];
            mdl_lamp[i] = mdl_mode[i] ? mdl_alt[i] : v[i];
        end
        prev_pin = v;
        chk(mdl_lamp, lamp);
        i_host.scan(rd);
        chk(mdl_lamp, rd);
        chk(mdl_lamp, i_host.status_bits);
        rdc(IDX_RAW_BTN, v);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial
    begin
        #2000000;
        miscompares++;
        end_sim();
    end
    // main sequence
    initial
    begin
        logic [15:0] v;
        logic [15:0] sels [5];
        sels = '{16'h00a0, 16'h0000, 16'h00a1, 16'h0001, 16'hffff};
        v = 16'($urandom(92577));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        for (int i = 0; i < 7; i++)
            mdl_word[i] = (i < 2) ? 1 : 0;
        for (int i = 0; i < 7; i++)
            rdc(i[3:0], mdl_word[i]);
        chk(0, hresp);
        $display("test reset done");
        for (int i = 2; i < 6; i++)
        begin
            v = 16'($urandom());
            wr(i[3:0], v);
            mdl_word[i] = v;
        end
        for (int j = 0; j < 2; j++)
            for (int k = 0; k < 5; k++)
            begin
                wr(j[3:0], sels[k]);
                if (sels[k] >= 1 && sels[k] <= 160)
                    mdl_word[j] = sels[k];
                rdc(j[3:0], mdl_word[j]);
            end
        for (int i = 0; i < 6; i++)
            rdc(i[3:0], mdl_word[i]);
        chk(mdl_word[0], top_line.sel);
        chk(mdl_word[2], top_line.lo);
        chk(mdl_word[3], top_line.hi);
        chk(mdl_word[1], bottom_line.sel);
        chk(mdl_word[4], bottom_line.lo);
        chk(mdl_word[5], bottom_line.hi);
        wr(IDX_STATUS, 16'hffff);
        rdc(IDX_STATUS, 0);
        wr(4'h7, 16'h1234);
        rdc(4'h7, 0);
        v = 16'($urandom());
        wr(IDX_BASE_WORD, v);
        rdc(IDX_BASE_WORD, v);
        $display("test words done");
        wr(IDX_IRQ_MASK, 16'h0001);
        press(4'h1);
        chk(1, irq);
        rdc(IDX_IRQ_STAT, 16'h0001);
        wr(IDX_IRQ_STAT, 16'h0001);
        rdc(IDX_IRQ_STAT, 0);
        chk(0, irq);
        press(4'h0);
        rdc(IDX_IRQ_STAT, 16'h0010);
        chk(0, irq);
        press(4'ha);
        press(4'h5);
        press(4'h0);
        $display("test momentary done");
        wr(IDX_BTN_MODE, 16'h0005);
        mdl_mode = 5;
        rdc(IDX_BTN_MODE, 5);
        for (int n = 0; n < 12; n++)
            press(4'($urandom_range(15)));
        $display("test alternate done");
        end_sim();
    end
endmodule
